// [src/irwc_pkg.sv]
// Package of offsets, field positions, reset values and timing for the reloadable counter
package irwc_pkg;
	// Register word addresses on the two-wire port
	localparam logic [7:0] OFF_RELOAD_LO = 8'hc5;
	localparam logic [7:0] OFF_RELOAD_HI = 8'hc6;
	localparam logic [7:0] OFF_LIVE_LO = 8'heb;
	localparam logic [7:0] OFF_LIVE_HI = 8'hec;
	localparam logic [7:0] OFF_CONFIG = 8'hf0;
	// Configuration field positions
	localparam int CFG_HOLD_BIT = 0;
	localparam int CFG_LATCH_BIT = 1;
	// Reset values
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [1:0] RST_CONFIG = 2'h0;
	// Slave address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h08;
	// Gating window: about 2*9 link clock periods, 45000 ns at 400 kHz
	localparam int CLK_MHZ = 40;
	localparam int TSTOP_NS = 45000;
	localparam logic [10:0] GATE_CYC = 11'(TSTOP_NS * CLK_MHZ / 1000);
	// Serial engine states, Gray along the usual path
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ADDR = 4'h1,
		S_ACK_ADDR = 4'h3,
		S_WADDR = 4'h2,
		S_ACK_WADDR = 4'h6,
		S_WDATA = 4'h7,
		S_ACK_WDATA = 4'h5,
		S_RDATA = 4'h4,
		S_RACK = 4'hc
	} irwc_state_t;
endpackage

// [src/irwc_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module irwc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic async_in,
	output logic level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// Shift chain; only the second stage reads the first
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Level changes once stages two and three agree
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			level_out <= RST_VAL;
		end else if (s2_reg == s3_reg) begin
			level_out <= s3_reg;
		end
	end
endmodule

// [src/irwc_top.sv]
// Reloadable 16-bit down counter with two-wire register port and output latching
`timescale 1ns/1ps
module irwc_top
	import irwc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic cnt_clk_i,
	input wire logic cnt_set_i,
	input wire logic cnt_rst_i,
	input wire logic [3:0] gpo_in,
	output logic [3:0] general_output_pin,
	output logic cnt_out
);
	import irwc_pkg::*;
	logic scl_lvl, sda_lvl, cclk_lvl, set_lvl, rst_lvl;
	logic scl_prev_reg, sda_prev_reg, cclk_prev_reg, set_prev_reg, rst_prev_reg;
	logic scl_rise, scl_fall, start_det, stop_det, cclk_rise, cnt_edge, set_evt, rst_evt;
	irwc_state_t state_reg;
	logic [3:0] bitcnt_reg;
	logic [7:0] shift_reg, ptr_reg, tx_reg, rd_byte;
	logic rw_reg, ack_ok_reg, wr_stb, waddr_stb, hold_en, latch_en, gating;
	logic [15:0] reload_reg, stage_reg, count_flop_chain;
	logic [1:0] config_reg;
	logic [10:0] gate_reg;
	logic armed_reg, set_pend_reg, latched_reg;
	// Pin synchronisers
	irwc_sync #(.RST_VAL(1'b1)) u_scl (.clk_sys(clk_sys), .arst_n(arst_n),
		.async_in(scl_i), .level_out(scl_lvl));
	irwc_sync #(.RST_VAL(1'b1)) u_sda (.clk_sys(clk_sys), .arst_n(arst_n),
		.async_in(sda_i), .level_out(sda_lvl));
	irwc_sync #(.RST_VAL(1'b0)) u_cclk (.clk_sys(clk_sys), .arst_n(arst_n),
		.async_in(cnt_clk_i), .level_out(cclk_lvl));
	irwc_sync #(.RST_VAL(1'b0)) u_set (.clk_sys(clk_sys), .arst_n(arst_n),
		.async_in(cnt_set_i), .level_out(set_lvl));
	irwc_sync #(.RST_VAL(1'b0)) u_rst (.clk_sys(clk_sys), .arst_n(arst_n),
		.async_in(cnt_rst_i), .level_out(rst_lvl));
	// Previous levels for edge detection
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			cclk_prev_reg <= 1'b0;
			set_prev_reg <= 1'b0;
			rst_prev_reg <= 1'b0;
		end else begin
			scl_prev_reg <= scl_lvl;
			sda_prev_reg <= sda_lvl;
			cclk_prev_reg <= cclk_lvl;
			set_prev_reg <= set_lvl;
			rst_prev_reg <= rst_lvl;
		end
	end
	// Edge and bus condition decode
	assign scl_rise = scl_lvl & ~scl_prev_reg;
	assign scl_fall = ~scl_lvl & scl_prev_reg;
	assign start_det = scl_lvl & scl_prev_reg & ~sda_lvl & sda_prev_reg;
	assign stop_det = scl_lvl & scl_prev_reg & sda_lvl & ~sda_prev_reg;
	assign cclk_rise = cclk_lvl & ~cclk_prev_reg;
	assign cnt_edge = cclk_rise & ~gating;
	assign set_evt = set_lvl & ~set_prev_reg;
	assign rst_evt = rst_lvl & ~rst_prev_reg;
	assign hold_en = config_reg[CFG_HOLD_BIT];
	assign latch_en = config_reg[CFG_LATCH_BIT];
	assign gating = (gate_reg != 11'h000);
	assign wr_stb = scl_fall && state_reg == S_WDATA && bitcnt_reg == 4'h8;
	assign waddr_stb = scl_fall && state_reg == S_WADDR && bitcnt_reg == 4'h8;
	// Read data selection; live bytes come straight off the chain
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_reg == OFF_RELOAD_LO) begin
			rd_byte = reload_reg[7:0];
		end else if (ptr_reg == OFF_RELOAD_HI) begin
			rd_byte = reload_reg[15:8];
		end else if (ptr_reg == OFF_LIVE_LO) begin
			rd_byte = count_flop_chain[7:0];
		end else if (ptr_reg == OFF_LIVE_HI) begin
			rd_byte = count_flop_chain[15:8];
		end else if (ptr_reg == OFF_CONFIG) begin
			rd_byte = {6'h00, config_reg};
		end
	end
	// Two-wire slave engine
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= S_IDLE;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			tx_reg <= 8'hff;
			rw_reg <= 1'b0;
			ack_ok_reg <= 1'b0;
			sda_o <= 1'b0; // Open drain: only ever pulls low
			sda_oe <= 1'b0;
		end else if (start_det) begin
			state_reg <= S_ADDR;
			bitcnt_reg <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			state_reg <= S_IDLE;
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				S_ADDR, S_WADDR, S_WDATA: begin
					shift_reg <= {shift_reg[6:0], sda_lvl};
					bitcnt_reg <= bitcnt_reg + 4'h1;
				end
				S_RACK: begin
					ack_ok_reg <= ~sda_lvl;
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				S_ADDR: begin
					if (bitcnt_reg == 4'h8) begin
						if (shift_reg[7:1] == DEV_ADDR) begin
							state_reg <= S_ACK_ADDR;
							rw_reg <= shift_reg[0];
							sda_oe <= 1'b1;
						end else begin
							state_reg <= S_IDLE;
						end
					end
				end
				S_ACK_ADDR, S_RACK: begin
					if ((state_reg == S_ACK_ADDR && rw_reg) || (state_reg == S_RACK && ack_ok_reg)) begin
						state_reg <= S_RDATA;
						tx_reg <= rd_byte;
						sda_oe <= ~rd_byte[7];
						ptr_reg <= ptr_reg + 8'h01;
						bitcnt_reg <= 4'h1;
					end else if (state_reg == S_ACK_ADDR) begin
						state_reg <= S_WADDR;
						sda_oe <= 1'b0;
						bitcnt_reg <= 4'h0;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				S_WADDR: begin
					if (bitcnt_reg == 4'h8) begin
						ptr_reg <= shift_reg;
						state_reg <= S_ACK_WADDR;
						sda_oe <= 1'b1;
					end
				end
				S_WDATA: begin
					if (bitcnt_reg == 4'h8) begin
						ptr_reg <= ptr_reg + 8'h01;
						state_reg <= S_ACK_WDATA;
						sda_oe <= 1'b1;
					end
				end
				S_ACK_WADDR, S_ACK_WDATA: begin
					state_reg <= S_WDATA;
					sda_oe <= 1'b0;
					bitcnt_reg <= 4'h0;
				end
				S_RDATA: begin
					if (bitcnt_reg == 4'h8) begin
						state_reg <= S_RACK;
						sda_oe <= 1'b0;
					end else begin
						tx_reg <= {tx_reg[6:0], 1'b1};
						sda_oe <= ~tx_reg[6];
						bitcnt_reg <= bitcnt_reg + 4'h1;
					end
				end
				default: ;
			endcase
		end
	end
	// Register writes, one byte per load
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reload_reg <= RST_RELOAD;
			config_reg <= RST_CONFIG;
		end else if (wr_stb) begin
			if (ptr_reg == OFF_RELOAD_LO) begin
				reload_reg[7:0] <= shift_reg;
			end else if (ptr_reg == OFF_RELOAD_HI) begin
				reload_reg[15:8] <= shift_reg;
			end else if (ptr_reg == OFF_CONFIG) begin
				config_reg <= shift_reg[1:0];
			end
		end
	end
	// Counter clock hold window
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gate_reg <= 11'h000;
		end else if (!hold_en) begin
			gate_reg <= 11'h000;
		end else if (waddr_stb && (shift_reg == OFF_RELOAD_LO || shift_reg == OFF_RELOAD_HI)) begin
			gate_reg <= GATE_CYC;
		end else if (gating) begin
			gate_reg <= gate_reg - 11'h001;
		end
	end
	// Set request held until a counter edge or reset event clears it; set wins over both
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			set_pend_reg <= 1'b0;
		end else if (set_evt) begin
			set_pend_reg <= 1'b1;
		end else if (cnt_edge || rst_evt) begin
			set_pend_reg <= 1'b0;
		end
	end
	// Down counter with two-edge reload path
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count_flop_chain <= RST_COUNT;
			stage_reg <= RST_RELOAD;
			armed_reg <= 1'b0;
			cnt_out <= 1'b0;
		end else begin
			cnt_out <= 1'b0;
			if (rst_evt) begin
				count_flop_chain <= reload_reg;
				armed_reg <= 1'b0;
			end else if (cnt_edge) begin
				if (armed_reg) begin
					count_flop_chain <= stage_reg;
					armed_reg <= 1'b0;
				end else if (count_flop_chain == 16'h0000 || set_pend_reg) begin
					stage_reg <= reload_reg;
					armed_reg <= 1'b1;
					cnt_out <= (count_flop_chain == 16'h0000);
				end else begin
					count_flop_chain <= count_flop_chain - 16'h0001;
				end
			end
		end
	end

	// Output latch on any start condition
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			latched_reg <= 1'b0;
			general_output_pin <= 4'h0;
		end else begin
			if (start_det && latch_en) begin
				latched_reg <= 1'b1;
			end else if (!latch_en) begin
				latched_reg <= 1'b0;
			end
			if (!latched_reg) begin
				general_output_pin <= gpo_in;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	load_on_uflow_a: assert property (cnt_edge && !rst_evt && !armed_reg && count_flop_chain == 16'h0000 |=> armed_reg && stage_reg == $past(reload_reg)) else $error("reload not staged on underflow");
	live_read_a: assert property (ptr_reg == OFF_LIVE_HI |-> rd_byte == count_flop_chain[15:8]) else $error("live high byte not from chain");
	low_byte_a: assert property (wr_stb && ptr_reg == OFF_RELOAD_LO |=> reload_reg[7:0] == $past(shift_reg) && $stable(reload_reg[15:8])) else $error("low byte load disturbed high");
	count_down_a: assert property (cnt_edge && !rst_evt && !armed_reg && !set_pend_reg && count_flop_chain != 16'h0000 |=> count_flop_chain == $past(count_flop_chain) - 16'h0001) else $error("count did not decrement");
	no_hold_a: assert property (!hold_en |=> !gating) else $error("gating while hold off");
	gate_start_a: assert property (waddr_stb && hold_en && (shift_reg == OFF_RELOAD_LO || shift_reg == OFF_RELOAD_HI) |=> gate_reg == GATE_CYC) else $error("gate not started on reload address");
	gate_len_a: assert property (hold_en && gate_reg == 11'h001 && !waddr_stb |=> !gating) else $error("gate window length wrong");
	gate_drop_a: assert property (gating && !rst_evt |=> $stable(count_flop_chain)) else $error("edge counted inside gate");
	two_edge_a: assert property (cnt_edge && !rst_evt && armed_reg |=> count_flop_chain == $past(stage_reg) && !armed_reg) else $error("second edge did not load");
	latch_set_a: assert property (start_det && latch_en |=> latched_reg) else $error("start did not latch");
	latch_hold_a: assert property (latched_reg |=> $stable(general_output_pin)) else $error("outputs moved while latched");
	gate_seen_c: cover property (waddr_stb && hold_en ##1 gating);
	uflow_seen_c: cover property (cnt_out ##[1:1000] cnt_edge && armed_reg);
	live_read_c: cover property (state_reg == S_RDATA && ptr_reg == OFF_LIVE_HI);
	latch_seen_c: cover property (latch_en && start_det ##1 latched_reg);
endmodule

// [tb/irwc_host.sv]
// Two-wire bus host model for the counter's register port
`timescale 1ns/1ps
module irwc_host
	import irwc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sda_oe,
	input wire logic sda_o,
	output logic scl_i,
	output logic sda_i
);
	import irwc_pkg::*;
	localparam int Q = 10;
	logic sda_low;
	logic scl_q;
	int nacks = 0;
	// Idle bus: both lines released to their pull-ups
	initial begin
		sda_low = 1'b0;
		scl_q = 1'b1;
	end
	// Open-drain lines with pull-ups; the device pulls low only when enabled with a zero
	assign sda_i = !(sda_low || (sda_oe && !sda_o));
	assign scl_i = scl_q;
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Data falls while clock is high, then clock falls
	task automatic start;
		sda_low <= 1'b0;
		hold(Q);
		scl_q <= 1'b1;
		hold(Q);
		sda_low <= 1'b1;
		hold(Q);
		scl_q <= 1'b0;
		hold(Q);
	endtask
	task automatic stop;
		sda_low <= 1'b1;
		hold(Q);
		scl_q <= 1'b1;
		hold(Q);
		sda_low <= 1'b0;
		hold(Q);
	endtask
	task automatic bitw(input logic b);
		sda_low <= !b;
		hold(Q);
		scl_q <= 1'b1;
		hold(2 * Q);
		scl_q <= 1'b0;
		hold(Q);
	endtask
	task automatic bitr(output logic b);
		sda_low <= 1'b0;
		hold(Q);
		scl_q <= 1'b1;
		hold(Q);
		b = sda_i;
		hold(Q);
		scl_q <= 1'b0;
		hold(Q);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bitw(d[i]);
		end
		bitr(b);
		ack = !b;
		if (b !== 1'b0) begin
			nacks++;
		end
	endtask
	task automatic rbyte(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) begin
			bitr(d[i]);
		end
		bitw(last);
	endtask
	// Low byte first, then high byte through the auto-incremented pointer
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		logic k;
		start();
		wbyte({DEV_ADDR, 1'b0}, k);
		wbyte(a, k);
		wbyte(d[7:0], k);
		wbyte(d[15:8], k);
		stop();
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		logic k;
		start();
		wbyte({DEV_ADDR, 1'b0}, k);
		wbyte(a, k);
		start();
		wbyte({DEV_ADDR, 1'b1}, k);
		rbyte(d[7:0], 1'b0);
		rbyte(d[15:8], 1'b1);
		stop();
	endtask
endmodule

// [tb/irwc_top_test.sv]
// Self-checking bench for the reloadable counter
`timescale 1ns/1ps
module irwc_top_test;
	import irwc_pkg::*;
	logic clk_sys;
	logic arst_n;
	logic cnt_clk_i;
	logic cnt_set_i;
	logic cnt_rst_i;
	logic [3:0] gpo_in;
	logic [3:0] general_output_pin;
	logic sda_o;
	logic sda_oe;
	logic scl_i;
	logic sda_i;
	logic cnt_out;
	logic [15:0] rv;
	logic ack;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int pulses = 0;
	always #12.5 clk_sys = !clk_sys;
	irwc_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
		.sda_o(sda_o), .sda_oe(sda_oe), .cnt_clk_i(cnt_clk_i), .cnt_set_i(cnt_set_i),
		.cnt_rst_i(cnt_rst_i), .gpo_in(gpo_in), .general_output_pin(general_output_pin),
		.cnt_out(cnt_out));
	irwc_host i_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .sda_o(sda_o), .scl_i(scl_i),
		.sda_i(sda_i));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Output pulse tally and run limit
	always @(posedge clk_sys) begin
		if (cnt_out === 1'b1) begin
			pulses <= pulses + 1;
		end
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic edges(input int n);
		repeat (n) begin
			cnt_clk_i <= 1'b1;
			i_host.hold(8);
			cnt_clk_i <= 1'b0;
			i_host.hold(8);
		end
	endtask
	// Set event when s is high, else reset event
	task automatic ev(input logic s);
		if (s) cnt_set_i <= 1'b1;
		else cnt_rst_i <= 1'b1;
		i_host.hold(8);
		cnt_set_i <= 1'b0;
		cnt_rst_i <= 1'b0;
		i_host.hold(8);
	endtask
	task automatic live(input logic [15:0] exp);
		i_host.rd16(OFF_LIVE_LO, rv);
		chk("live count", exp, rv);
	endtask
	task automatic t_regs;
		live(RST_COUNT);
		i_host.rd16(OFF_RELOAD_LO, rv);
		chk("reload", RST_RELOAD, rv);
		i_host.wr16(OFF_LIVE_LO, 16'h1234);
		live(RST_COUNT);
		i_host.rd16(8'hf8, rv);
		chk("unmapped", 16'h0000, rv);
		chk("outputs", 16'h0000, {12'h000, general_output_pin});
		chk("data drive", 16'h0000, {15'h0000, sda_o});
	endtask
	task automatic t_reload;
		int p0;
		i_host.wr16(OFF_RELOAD_LO, 16'h0003);
		i_host.rd16(OFF_RELOAD_LO, rv);
		chk("reload", 16'h0003, rv);
		ev(1'b0);
		live(16'h0003);
		p0 = pulses;
		edges(3);
		live(16'h0000);
		edges(1);
		live(16'h0000);
		chk("pulses", 16'(p0 + 1), 16'(pulses));
		edges(1);
		live(16'h0003);
		ev(1'b1);
		edges(1);
		live(16'h0003);
		edges(2);
		live(16'h0002);
		chk("pulses", 16'(p0 + 1), 16'(pulses));
	endtask
	task automatic t_hold;
		i_host.wr16(OFF_CONFIG, 16'h0001);
		ev(1'b0);
		i_host.wr16(OFF_RELOAD_LO, 16'h0003);
		edges(3);
		live(16'h0003);
		i_host.hold(300);
		edges(1);
		live(16'h0002);
		i_host.rd16(OFF_RELOAD_LO, rv);
		edges(1);
		chk("reload", 16'h0003, rv);
		live(16'h0002);
		i_host.wr16(OFF_CONFIG, 16'h0000);
		i_host.rd16(OFF_RELOAD_LO, rv);
		edges(1);
		live(16'h0001);
	endtask
	task automatic t_latch;
		gpo_in <= 4'h5;
		i_host.hold(4);
		chk("outputs", 16'h0005, {12'h000, general_output_pin});
		i_host.wr16(OFF_CONFIG, 16'h0002);
		i_host.start();
		i_host.wbyte(8'h44, ack);
		i_host.stop();
		chk("foreign ack", 16'h0000, {15'h0000, ack});
		gpo_in <= 4'ha;
		i_host.hold(4);
		chk("outputs", 16'h0005, {12'h000, general_output_pin});
		i_host.wr16(OFF_CONFIG, 16'h0000);
		i_host.hold(4);
		chk("outputs", 16'h000a, {12'h000, general_output_pin});
	endtask
	initial begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		cnt_clk_i = 1'b0;
		cnt_set_i = 1'b0;
		cnt_rst_i = 1'b0;
		gpo_in = 4'h0;
		i_host.hold(4);
		arst_n <= 1'b1;
		i_host.hold(8);
		t_regs();
		t_reload();
		t_hold();
		t_latch();
		chk("nacks", 16'h0001, 16'(i_host.nacks));
		end_sim();
	end
endmodule
